/* File: pkg/dsl_cfg.svh */
`ifndef DSL_CFG_SVH
`define DSL_CFG_SVH

// -----------------------------------------------------------------------------
// Register map (byte addresses on the AXI4-Lite bus).
// -----------------------------------------------------------------------------
`define DSL_ADDR_W 8
`define DSL_ADDR_CTRL 8'h00
`define DSL_ADDR_STATUS 8'h04
`define DSL_ADDR_IRQ_STATUS 8'h08
`define DSL_ADDR_IRQ_CLEAR 8'h0C
`define DSL_ADDR_IRQ_ENABLE 8'h10
`define DSL_ADDR_LATCHED 8'h14

// -----------------------------------------------------------------------------
// Control register fields and reset values.
// -----------------------------------------------------------------------------
`define DSL_CTRL_EXT_LR_BIT 0
`define DSL_CTRL_SCADA_EN_BIT 1
`define DSL_CTRL_PC_CLEAR_BIT 2
`define DSL_CTRL_EXT_LR_RST 1'h0
`define DSL_CTRL_SCADA_EN_RST 1'h1

// -----------------------------------------------------------------------------
// Status register fields.
// -----------------------------------------------------------------------------
`define DSL_STAT_LOCAL_LSB 0
`define DSL_STAT_WARN_BIT 4
`define DSL_STAT_ERR_BIT 5
`define DSL_STAT_CLEAR_BIT 6
`define DSL_STAT_CANCEL_BIT 7
`define DSL_STAT_SRC_LSB 8
`define DSL_STAT_SRC_MSB 15
`define DSL_STAT_EXTWARN_BIT 16

// -----------------------------------------------------------------------------
// Interrupt status, clear and enable layout.
// -----------------------------------------------------------------------------
`define DSL_IRQ_W 8
`define DSL_IRQ_WARN_BIT 0
`define DSL_IRQ_ERR_BIT 1
`define DSL_IRQ_CLEAR_BIT 2
`define DSL_IRQ_CANCEL_BIT 3
`define DSL_IRQ_GROUP_LSB 4
`define DSL_IRQ_EN_RST 8'h00

// -----------------------------------------------------------------------------
// Sizes and fixed levels.
// -----------------------------------------------------------------------------
`define DSL_GROUPS 4
`define DSL_LED_COUNT 8
`define DSL_WARN_SRC_W 8
`define DSL_CONST_LOW 1'h0
`define DSL_CONST_HIGH 1'h1
`define DSL_GROUP_RST_LOCAL 1'h1
`define DSL_LAMP_GREEN_BIT 0
`define DSL_LAMP_YELLOW_BIT 1
`define DSL_LAMP_RED_BIT 2

`endif

/* File: pkg/dsl_pkg.sv */
package dsl_pkg;

	// AXI4-Lite response codes used by the slave.
	typedef enum logic [1:0] {
		DSL_RESP_OKAY = 2'b00,
		DSL_RESP_SLVERR = 2'b10
	} dsl_resp_type;

	// Colour shown by the device-state indicator.
	typedef enum logic [1:0] {
		DSL_LED_GREEN = 2'b00,
		DSL_LED_YELLOW = 2'b01,
		DSL_LED_RED = 2'b10
	} dsl_colour_type;

endpackage

/* File: core/dsl_sync.sv */
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for a bundle of independent level inputs.
module dsl_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} dsl_sync_state_type;

	dsl_sync_state_type state_ff;
	dsl_sync_state_type nxt_state;

	// The first stage is read only by the second stage.
	always_comb begin
		nxt_state.meta = async_in;
		nxt_state.stable = state_ff.meta;
	end

	// Both stages clear to zero under reset.
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign sync_out = state_ff.stable;

endmodule

`default_nettype wire

/* File: core/dsl_common.sv */
// Overview of operation
// - Indicator green normal, yellow warning, red error.
// - Eight internal conditions raise the warning state.
// - Error also drives power-supply module output.
// - External warning input adds to warning sources.
// - Composed warning output follows warning state.
// - Four reset sources clear latched indicators.
// - Cancel button press drives acknowledge output.
// - Composed clear output shows combined reset request.
// - Up to four independent Local/Remote groups.
// - External local/remote requests set group state.
// - Each group drives local and remote indications.
// - Touch-screen control toggles group Local/Remote.
// - Enable setting zero ignores external requests.
// - Constant low and constant high outputs.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "dsl_cfg.svh"

module dsl_common
	import dsl_pkg::*;
#(
	parameter int GROUPS = `DSL_GROUPS,
	parameter int LED_COUNT = `DSL_LED_COUNT
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [`DSL_WARN_SRC_W-1:0] warn_source_in,
	input wire logic error_in,
	input wire logic external_warning_in,
	input wire logic panel_clear_button_in,
	input wire logic scada_clear_in,
	input wire logic indicator_clear_in,
	input wire logic cancel_button_in,
	input wire logic [GROUPS-1:0] touch_toggle_in,
	input wire logic [GROUPS-1:0] group_local_request_in,
	input wire logic [GROUPS-1:0] group_remote_request_in,
	input wire logic [LED_COUNT-1:0] indicator_set_in,
	input wire logic [`DSL_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [`DSL_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic state_green_out,
	output logic state_yellow_out,
	output logic state_red_out,
	output logic psu_error_out,
	output logic composed_warning_out,
	output logic composed_clear_out,
	output logic cancel_press_out,
	output logic [LED_COUNT-1:0] latched_indicator_out,
	output logic [GROUPS-1:0] group_is_local_out,
	output logic [GROUPS-1:0] group_is_remote_out,
	output logic constant_low_out,
	output logic constant_high_out,
	output logic irq_out
);

	// -------------------------------------------------------------------------
	// Parameter checks.
	// -------------------------------------------------------------------------
	// The status and interrupt layouts leave room for four groups at most.
	if (GROUPS < 1 || GROUPS > 4) begin : gen_bad_groups
		$error("GROUPS must lie between 1 and 4.");
	end
	if (LED_COUNT < 1 || LED_COUNT > 32) begin : gen_bad_leds
		$error("LED_COUNT must lie between 1 and 32.");
	end

	localparam int SYNC_W = `DSL_WARN_SRC_W + 6 + 3 * GROUPS + LED_COUNT;

	// -------------------------------------------------------------------------
	// Module state.
	// -------------------------------------------------------------------------
	typedef struct packed {
		logic aw_have;
		logic [`DSL_ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic ext_lr_en;
		logic scada_en;
		logic pc_clear;
		logic [`DSL_IRQ_W-1:0] irq_en;
		logic [`DSL_IRQ_W-1:0] irq_stat;
		logic irq;
		logic [GROUPS-1:0] is_local;
		logic [GROUPS-1:0] is_remote;
		logic [GROUPS-1:0] touch_prev;
		logic warn;
		logic err;
		logic [2:0] lamp;
		logic clear;
		logic cancel;
		logic const_lo;
		logic const_hi;
		logic [LED_COUNT-1:0] led;
	} dsl_core_state_type;

	dsl_core_state_type state_ff;
	dsl_core_state_type nxt_state;

	logic [SYNC_W-1:0] raw_pins;
	logic [SYNC_W-1:0] sync_pins;
	logic [`DSL_WARN_SRC_W-1:0] src_s;
	logic err_s;
	logic extwarn_s;
	logic button_s;
	logic scada_s;
	logic indclr_s;
	logic cancel_s;
	logic [GROUPS-1:0] touch_s;
	logic [GROUPS-1:0] loc_s;
	logic [GROUPS-1:0] rem_s;
	logic [LED_COUNT-1:0] set_s;

	// -------------------------------------------------------------------------
	// Input synchronisation.
	// -------------------------------------------------------------------------
	// Every panel and user-logic level passes two flip-flops before use.
	assign raw_pins = {warn_source_in, error_in, external_warning_in, panel_clear_button_in,
		scada_clear_in, indicator_clear_in, cancel_button_in, touch_toggle_in,
		group_local_request_in, group_remote_request_in, indicator_set_in};

	dsl_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.async_in(raw_pins),
		.sync_out(sync_pins)
	);

	// Split the synchronised bundle back into its signals.
	assign {src_s, err_s, extwarn_s, button_s, scada_s, indclr_s, cancel_s, touch_s,
		loc_s, rem_s, set_s} = sync_pins;

	// -------------------------------------------------------------------------
	// Next-state logic.
	// -------------------------------------------------------------------------
	always_comb begin
		logic clear_req;
		logic [`DSL_IRQ_W-1:0] events;
		logic [`DSL_IRQ_W-1:0] clear_mask;
		logic [31:0] rd_word;
		logic rd_ok;
		clear_req = 1'b0;
		events = '0;
		clear_mask = '0;
		rd_word = '0;
		rd_ok = 1'b1;
		nxt_state = state_ff;

		// Warning and error composition with error taking the red colour.
		nxt_state.warn = (|src_s) | extwarn_s;
		nxt_state.err = err_s;
		nxt_state.lamp = '0;
		if (err_s) begin
			nxt_state.lamp[`DSL_LAMP_RED_BIT] = 1'b1;
		end else if (nxt_state.warn) begin
			nxt_state.lamp[`DSL_LAMP_YELLOW_BIT] = 1'b1;
		end else begin
			nxt_state.lamp[`DSL_LAMP_GREEN_BIT] = 1'b1;
		end

		// Reset request from panel, computer, enabled SCADA or user logic.
		clear_req = button_s | state_ff.pc_clear | (scada_s & state_ff.scada_en) | indclr_s;
		nxt_state.clear = clear_req;
		nxt_state.pc_clear = 1'b0;
		// A set in the same cycle as the clear survives it.
		nxt_state.led = (clear_req ? '0 : state_ff.led) | set_s;
		nxt_state.cancel = cancel_s;
		nxt_state.const_lo = `DSL_CONST_LOW;
		nxt_state.const_hi = `DSL_CONST_HIGH;

		// Local/Remote groups, each updated on its own inputs only.
		nxt_state.touch_prev = touch_s;
		for (int g = 0; g < GROUPS; g++) begin
			if (state_ff.ext_lr_en && loc_s[g] && !rem_s[g]) begin
				nxt_state.is_local[g] = 1'b1;
			end else if (state_ff.ext_lr_en && rem_s[g] && !loc_s[g]) begin
				nxt_state.is_local[g] = 1'b0;
			end else if (touch_s[g] && !state_ff.touch_prev[g]) begin
				nxt_state.is_local[g] = !state_ff.is_local[g];
			end
			nxt_state.is_remote[g] = !nxt_state.is_local[g];
			events[`DSL_IRQ_GROUP_LSB + g] = nxt_state.is_local[g] ^ state_ff.is_local[g];
		end

		// Rising edges of the composed conditions become interrupt events.
		events[`DSL_IRQ_WARN_BIT] = nxt_state.warn & !state_ff.warn;
		events[`DSL_IRQ_ERR_BIT] = nxt_state.err & !state_ff.err;
		events[`DSL_IRQ_CLEAR_BIT] = clear_req & !state_ff.clear;
		events[`DSL_IRQ_CANCEL_BIT] = cancel_s & !state_ff.cancel;

		// Write address and write data are captured independently.
		if (s_axi_awvalid_in && state_ff.awready) begin
			nxt_state.aw_have = 1'b1;
			nxt_state.aw_addr = s_axi_awaddr_in;
			nxt_state.awready = 1'b0;
		end
		if (s_axi_wvalid_in && state_ff.wready) begin
			nxt_state.w_have = 1'b1;
			nxt_state.w_data = s_axi_wdata_in;
			nxt_state.w_strb = s_axi_wstrb_in;
			nxt_state.wready = 1'b0;
		end

		// Perform the write once both halves are held.
		if (state_ff.aw_have && state_ff.w_have && !state_ff.bvalid) begin
			nxt_state.aw_have = 1'b0;
			nxt_state.w_have = 1'b0;
			nxt_state.bvalid = 1'b1;
			nxt_state.bresp = DSL_RESP_OKAY;
			if (state_ff.aw_addr == `DSL_ADDR_CTRL) begin
				if (state_ff.w_strb[0]) begin
					nxt_state.ext_lr_en = state_ff.w_data[`DSL_CTRL_EXT_LR_BIT];
					nxt_state.scada_en = state_ff.w_data[`DSL_CTRL_SCADA_EN_BIT];
					nxt_state.pc_clear = state_ff.w_data[`DSL_CTRL_PC_CLEAR_BIT];
				end
			end else if (state_ff.aw_addr == `DSL_ADDR_IRQ_CLEAR) begin
				if (state_ff.w_strb[0]) begin
					clear_mask = state_ff.w_data[`DSL_IRQ_W-1:0];
				end
			end else if (state_ff.aw_addr == `DSL_ADDR_IRQ_ENABLE) begin
				if (state_ff.w_strb[0]) begin
					nxt_state.irq_en = state_ff.w_data[`DSL_IRQ_W-1:0];
				end
			end else if (state_ff.aw_addr == `DSL_ADDR_STATUS ||
				state_ff.aw_addr == `DSL_ADDR_IRQ_STATUS ||
				state_ff.aw_addr == `DSL_ADDR_LATCHED) begin
				nxt_state.bresp = DSL_RESP_OKAY;
			end else begin
				nxt_state.bresp = DSL_RESP_SLVERR;
			end
		end
		if (state_ff.bvalid && s_axi_bready_in) begin
			nxt_state.bvalid = 1'b0;
			nxt_state.awready = 1'b1;
			nxt_state.wready = 1'b1;
		end

		// Sticky interrupt bits; a new event wins over a clear.
		nxt_state.irq_stat = (state_ff.irq_stat & ~clear_mask) | events;
		nxt_state.irq = |(nxt_state.irq_stat & nxt_state.irq_en);

		// Read decode; answer is registered on the same edge that takes the address.
		if (s_axi_araddr_in == `DSL_ADDR_CTRL) begin
			rd_word[`DSL_CTRL_EXT_LR_BIT] = state_ff.ext_lr_en;
			rd_word[`DSL_CTRL_SCADA_EN_BIT] = state_ff.scada_en;
		end else if (s_axi_araddr_in == `DSL_ADDR_STATUS) begin
			rd_word[`DSL_STAT_LOCAL_LSB +: GROUPS] = state_ff.is_local;
			rd_word[`DSL_STAT_WARN_BIT] = state_ff.warn;
			rd_word[`DSL_STAT_ERR_BIT] = state_ff.err;
			rd_word[`DSL_STAT_CLEAR_BIT] = state_ff.clear;
			rd_word[`DSL_STAT_CANCEL_BIT] = state_ff.cancel;
			rd_word[`DSL_STAT_SRC_MSB:`DSL_STAT_SRC_LSB] = src_s;
			rd_word[`DSL_STAT_EXTWARN_BIT] = extwarn_s;
		end else if (s_axi_araddr_in == `DSL_ADDR_IRQ_STATUS) begin
			rd_word[`DSL_IRQ_W-1:0] = state_ff.irq_stat;
		end else if (s_axi_araddr_in == `DSL_ADDR_IRQ_CLEAR) begin
			rd_word = '0;
		end else if (s_axi_araddr_in == `DSL_ADDR_IRQ_ENABLE) begin
			rd_word[`DSL_IRQ_W-1:0] = state_ff.irq_en;
		end else if (s_axi_araddr_in == `DSL_ADDR_LATCHED) begin
			rd_word[LED_COUNT-1:0] = state_ff.led;
		end else begin
			rd_ok = 1'b0;
		end
		if (s_axi_arvalid_in && state_ff.arready) begin
			nxt_state.arready = 1'b0;
			nxt_state.rvalid = 1'b1;
			nxt_state.rdata = rd_word;
			nxt_state.rresp = rd_ok ? DSL_RESP_OKAY : DSL_RESP_SLVERR;
		end
		if (state_ff.rvalid && s_axi_rready_in) begin
			nxt_state.rvalid = 1'b0;
			nxt_state.arready = 1'b1;
		end
	end

	// -------------------------------------------------------------------------
	// State register.
	// -------------------------------------------------------------------------
	// Groups start Local and the constant-high flop starts high.
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_ff <= '0;
			state_ff.awready <= 1'b1;
			state_ff.wready <= 1'b1;
			state_ff.arready <= 1'b1;
			state_ff.ext_lr_en <= `DSL_CTRL_EXT_LR_RST;
			state_ff.scada_en <= `DSL_CTRL_SCADA_EN_RST;
			state_ff.irq_en <= `DSL_IRQ_EN_RST;
			state_ff.is_local <= {GROUPS{`DSL_GROUP_RST_LOCAL}};
			state_ff.is_remote <= {GROUPS{~`DSL_GROUP_RST_LOCAL}};
			state_ff.const_lo <= `DSL_CONST_LOW;
			state_ff.const_hi <= `DSL_CONST_HIGH;
			state_ff.lamp[`DSL_LAMP_GREEN_BIT] <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// -------------------------------------------------------------------------
	// Outputs, each taken from a flip-flop.
	// -------------------------------------------------------------------------
	assign s_axi_awready_out = state_ff.awready;
	assign s_axi_wready_out = state_ff.wready;
	assign s_axi_bresp_out = state_ff.bresp;
	assign s_axi_bvalid_out = state_ff.bvalid;
	assign s_axi_arready_out = state_ff.arready;
	assign s_axi_rdata_out = state_ff.rdata;
	assign s_axi_rresp_out = state_ff.rresp;
	assign s_axi_rvalid_out = state_ff.rvalid;
	assign state_green_out = state_ff.lamp[`DSL_LAMP_GREEN_BIT];
	assign state_yellow_out = state_ff.lamp[`DSL_LAMP_YELLOW_BIT];
	assign state_red_out = state_ff.lamp[`DSL_LAMP_RED_BIT];
	assign psu_error_out = state_ff.err;
	assign composed_warning_out = state_ff.warn;
	assign composed_clear_out = state_ff.clear;
	assign cancel_press_out = state_ff.cancel;
	assign latched_indicator_out = state_ff.led;
	assign group_is_local_out = state_ff.is_local;
	assign group_is_remote_out = state_ff.is_remote;
	assign constant_low_out = state_ff.const_lo;
	assign constant_high_out = state_ff.const_hi;
	assign irq_out = state_ff.irq;

endmodule

`default_nettype wire

/* File: tb/dsl_common_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Checker on the pins of the common block.
// ----------------------------------------
module dsl_common_chk #(
	parameter int GROUPS = 4
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] warn_source_in,
	input wire logic error_in,
	input wire logic external_warning_in,
	input wire logic cancel_button_in,
	input wire logic indicator_clear_in,
	input wire logic state_green_out,
	input wire logic state_yellow_out,
	input wire logic state_red_out,
	input wire logic psu_error_out,
	input wire logic composed_warning_out,
	input wire logic composed_clear_out,
	input wire logic cancel_press_out,
	input wire logic [GROUPS-1:0] group_is_local_out,
	input wire logic [GROUPS-1:0] group_is_remote_out,
	input wire logic constant_low_out,
	input wire logic constant_high_out
);
	// Inputs need two sync edges and one output edge, so four samples settle them.
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	red_on_error_a: assert property (error_in [*4] |-> state_red_out)
		else $error("red colour missing while error present");
	one_colour_a: assert property ($onehot({state_green_out, state_yellow_out, state_red_out}))
		else $error("colour outputs not one-hot");
	green_when_calm_a: assert property ((!error_in && !external_warning_in &&
		warn_source_in == 8'h00) [*4] |-> state_green_out) else $error("green missing");
	psu_with_red_a: assert property (psu_error_out == state_red_out)
		else $error("power supply error output differs from red");
	warn_sources_a: assert property ((external_warning_in || |warn_source_in) [*4]
		|-> composed_warning_out && !state_green_out) else $error("warning missing");
	cancel_level_a: assert property (cancel_button_in [*4] |-> cancel_press_out)
		else $error("cancel press output missing");
	clear_input_a: assert property (indicator_clear_in [*4] |-> composed_clear_out)
		else $error("composed clear output missing");
	group_pair_a: assert property (group_is_local_out == ~group_is_remote_out)
		else $error("group local and remote outputs not complementary");
	fixed_levels_a: assert property (constant_high_out && !constant_low_out)
		else $error("constant outputs wrong");
endmodule
bind dsl_common dsl_common_chk #(.GROUPS(GROUPS)) u_chk (.*);
`default_nettype wire

/* File: tb/dsl_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Front panel and user logic driving the block.
// ----------------------------------------
module dsl_far_model (
	input wire logic sys_clk_in,
	output logic [7:0] warn_source_in,
	output logic error_in,
	output logic external_warning_in,
	output logic panel_clear_button_in,
	output logic scada_clear_in,
	output logic indicator_clear_in,
	output logic cancel_button_in,
	output logic [3:0] touch_toggle_in,
	output logic [3:0] group_local_request_in,
	output logic [3:0] group_remote_request_in,
	output logic [7:0] indicator_set_in
);
	// Every level starts released, then moves just after a rising edge.
	initial begin
		{warn_source_in, error_in, external_warning_in} = 10'h000;
		{panel_clear_button_in, scada_clear_in, indicator_clear_in, cancel_button_in} = 4'h0;
		{touch_toggle_in, group_local_request_in, group_remote_request_in} = 12'h000;
		indicator_set_in = 8'h00;
	end
	task set_warn(input logic [7:0] w, input logic e, input logic x);
		@(posedge sys_clk_in);
		warn_source_in <= w;
		error_in <= e;
		external_warning_in <= x;
	endtask
	task set_btn(input logic [3:0] b);
		@(posedge sys_clk_in);
		{cancel_button_in, indicator_clear_in, scada_clear_in, panel_clear_button_in} <= b;
	endtask
	task set_grp(input logic [3:0] t, input logic [3:0] l, input logic [3:0] r);
		@(posedge sys_clk_in);
		touch_toggle_in <= t;
		group_local_request_in <= l;
		group_remote_request_in <= r;
	endtask
	task set_led(input logic [7:0] s);
		@(posedge sys_clk_in);
		indicator_set_in <= s;
	endtask
endmodule
`default_nettype wire

/* File: tb/dsl_common_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dsl_cfg.svh"
// ----------------------------------------
// Self-checking bench for the common block.
// ----------------------------------------
module dsl_common_tb_top
	import dsl_pkg::*;
;
	logic sys_clk_in, resetn_in, error_in, external_warning_in, panel_clear_button_in;
	logic scada_clear_in, indicator_clear_in, cancel_button_in, s_axi_awvalid_in;
	logic s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, state_green_out, state_yellow_out, state_red_out, psu_error_out;
	logic composed_warning_out, composed_clear_out, cancel_press_out, irq_out;
	logic constant_low_out, constant_high_out, pin_chk;
	logic [7:0] warn_source_in, indicator_set_in, latched_indicator_out;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [3:0] touch_toggle_in, group_local_request_in, group_remote_request_in;
	logic [3:0] group_is_local_out, group_is_remote_out, s_axi_wstrb_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [17:0] pins;
	logic [33:0] pq[$], bq[$], rq[$];
	int fails, n_tests, i;
	logic [31:0] seed;
	logic [7:0] ws, led_exp;

	dsl_common u_dut (.*);
	dsl_far_model u_far (.*);

	// Pin snapshot compared as one vector.
	assign pins = {constant_high_out, constant_low_out, state_green_out, state_yellow_out,
		state_red_out, psu_error_out, composed_warning_out, composed_clear_out,
		cancel_press_out, irq_out, group_is_local_out, group_is_remote_out};

	function automatic logic [17:0] mk(input logic e, w, c, k, q, input logic [3:0] l);
		return {2'h2, !e && !w, w && !e, e, e, w, c, k, q, l, ~l};
	endfunction

	task test_done;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Queues the expected pins once the three-edge input path has settled.
	task pc(input logic [17:0] e);
		repeat (3) @(posedge sys_clk_in);
		pq.push_back({8'h00, led_exp, e});
		pin_chk <= 1'h1;
		@(posedge sys_clk_in);
		pin_chk <= 1'h0;
	endtask

	task wt;
		repeat (4) @(posedge sys_clk_in);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ta, tw, tb;
		tb = 1'h0;
		bq.push_back({32'h0, e});
		@(posedge sys_clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		while (!tb) begin
			@(negedge sys_clk_in);
			ta = s_axi_awready_out;
			tw = s_axi_wready_out;
			tb = s_axi_bvalid_out;
			@(posedge sys_clk_in);
			if (ta) s_axi_awvalid_in <= 1'h0;
			if (tw) s_axi_wvalid_in <= 1'h0;
		end
		s_axi_bready_in <= 1'h0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ta, tr;
		tr = 1'h0;
		rq.push_back({e, d});
		@(posedge sys_clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		while (!tr) begin
			@(negedge sys_clk_in);
			ta = s_axi_arready_out;
			tr = s_axi_rvalid_out;
			@(posedge sys_clk_in);
			if (ta) s_axi_arvalid_in <= 1'h0;
		end
		s_axi_rready_in <= 1'h0;
	endtask

	// Takes the oldest note off each queue as its result appears.
	always @(posedge sys_clk_in) begin
		if (pin_chk) chk("pins", pq.pop_front(), {8'h00, latched_indicator_out, pins});
		if (s_axi_bvalid_out && s_axi_bready_in) chk("bresp", bq.pop_front(), {32'h0, s_axi_bresp_out});
		if (s_axi_rvalid_out && s_axi_rready_in) chk("read", rq.pop_front(), {s_axi_rresp_out, s_axi_rdata_out});
	end

	// Clock at 125 MHz.
	initial begin
		sys_clk_in = 1'h0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end

	// Watchdog sized well above the expected run.
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		fails++;
		test_done;
	end

	// Main sequence of scenarios.
	initial begin
		{resetn_in, pin_chk, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 5'h00;
		{s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in} = 18'h00000;
		s_axi_wdata_in = 32'h0;
		led_exp = 8'h00;
		s_axi_wstrb_in = 4'hF;
		seed = 32'h042905C1;
		repeat (2) @(posedge sys_clk_in);
		resetn_in <= 1'h1;
		pc(mk(0, 0, 0, 0, 0, 4'hF));
		rd(`DSL_ADDR_CTRL, 32'h2, DSL_RESP_OKAY);
		rd(`DSL_ADDR_IRQ_ENABLE, 32'h0, DSL_RESP_OKAY);
		rd(8'h18, 32'h0, DSL_RESP_SLVERR);
		wr(8'h18, 32'hFF, DSL_RESP_SLVERR);
		$display("test reset done");
		wr(`DSL_ADDR_IRQ_CLEAR, 32'hFF, DSL_RESP_OKAY);
		wr(`DSL_ADDR_IRQ_ENABLE, 32'h1, DSL_RESP_OKAY);
		u_far.set_warn(8'h00, 1'h0, 1'h1);
		pc(mk(0, 1, 0, 0, 1, 4'hF));
		wr(`DSL_ADDR_IRQ_CLEAR, 32'h1, DSL_RESP_OKAY);
		pc(mk(0, 1, 0, 0, 0, 4'hF));
		wr(`DSL_ADDR_IRQ_ENABLE, 32'h0, DSL_RESP_OKAY);
		$display("test interrupt done");
		for (i = 0; i < 11; i++) begin
			ws = (i < 8) ? 8'h01 << i : ((i == 10) ? 8'($random(seed)) : 8'h00);
			u_far.set_warn(ws, i >= 9, i == 8);
			pc(mk(i >= 9, ws != 8'h00 || i == 8, 0, 0, 0, 4'hF));
		end
		u_far.set_warn(8'h00, 1'h0, 1'h0);
		pc(mk(0, 0, 0, 0, 0, 4'hF));
		$display("test colour done");
		u_far.set_btn(4'h8);
		pc(mk(0, 0, 0, 1, 0, 4'hF));
		for (i = 0; i < 5; i++) begin
			led_exp = (i == 4) ? 8'hA5 : 8'h00;
			if (i == 4) wr(`DSL_ADDR_CTRL, 32'h0, DSL_RESP_OKAY);
			u_far.set_led(8'hA5);
			wt;
			u_far.set_led(8'h00);
			rd(`DSL_ADDR_LATCHED, 32'hA5, DSL_RESP_OKAY);
			if (i == 3) wr(`DSL_ADDR_CTRL, 32'h6, DSL_RESP_OKAY);
			else u_far.set_btn((i == 4) ? 4'h2 : 4'h1 << i);
			pc(mk(0, 0, i < 3, 0, 0, 4'hF));
			u_far.set_btn(4'h0);
			wt;
			rd(`DSL_ADDR_LATCHED, (i == 4) ? 32'hA5 : 32'h0, DSL_RESP_OKAY);
		end
		$display("test clear done");
		u_far.set_grp(4'h2, 4'h0, 4'h0);
		wt;
		u_far.set_grp(4'h0, 4'h0, 4'hF);
		pc(mk(0, 0, 0, 0, 0, 4'hD));
		u_far.set_grp(4'h0, 4'h0, 4'h0);
		wr(`DSL_ADDR_CTRL, 32'h3, DSL_RESP_OKAY);
		u_far.set_grp(4'h0, 4'h0, 4'h1);
		pc(mk(0, 0, 0, 0, 0, 4'hC));
		u_far.set_grp(4'h0, 4'h4, 4'h4);
		pc(mk(0, 0, 0, 0, 0, 4'hC));
		u_far.set_grp(4'h0, 4'h2, 4'h0);
		pc(mk(0, 0, 0, 0, 0, 4'hE));
		$display("test groups done");
		test_done;
	end
endmodule
`default_nettype wire
